// ### core/probe_regs_pkg.sv
// Constants, types and helpers for the probe's holding-register bank.
// Assumes word addresses are the zero-based protocol addresses of 16-bit registers.
package probe_regs_pkg;

	// Register addresses (protocol address = register number minus one)
	localparam logic [15:0] ADDR_ERROR_FLAG     = 16'h0200;
	localparam logic [15:0] ADDR_ERROR_SUM_LO   = 16'h0203;
	localparam logic [15:0] ADDR_ERROR_SUM_HI   = 16'h0204;
	localparam logic [15:0] ADDR_HASH_LO        = 16'h0205;
	localparam logic [15:0] ADDR_HASH_HI        = 16'h0206;
	localparam logic [15:0] ADDR_SMOOTH_LO      = 16'h0310;
	localparam logic [15:0] ADDR_SMOOTH_HI      = 16'h0311;
	localparam logic [15:0] ADDR_SLAVE_ID       = 16'h0600;
	localparam logic [15:0] ADDR_BAUD_SELECT    = 16'h0601;
	localparam logic [15:0] ADDR_CHAR_FRAMING   = 16'h0602;
	localparam logic [15:0] ADDR_REPLY_DELAY    = 16'h0603;
	localparam logic [15:0] ADDR_PROTOCOL       = 16'h0604;
	localparam logic [15:0] ADDR_RESTART        = 16'h0605;
	localparam logic [15:0] ADDR_INT_TEST       = 16'h1F00;
	localparam logic [15:0] ADDR_FLOAT_TEST_LO  = 16'h1F01;
	localparam logic [15:0] ADDR_FLOAT_TEST_HI  = 16'h1F02;
	localparam logic [15:0] ADDR_TEXT_TEST_0    = 16'h1F03;
	localparam logic [15:0] ADDR_TEXT_TEST_1    = 16'h1F04;
	localparam logic [15:0] ADDR_TEXT_TEST_2    = 16'h1F05;
	localparam logic [15:0] ADDR_TEXT_TEST_3    = 16'h1F06;

	// Error flag values
	localparam logic [15:0] ERROR_FLAG_ACTIVE   = 16'h0000;
	localparam logic [15:0] ERROR_FLAG_CLEAR    = 16'h0001;

	// Error weights, one bit each
	localparam logic [31:0] ERR_TEMP_MEAS       = 32'h0000_0001;
	localparam logic [31:0] ERR_HUM_MEAS        = 32'h0000_0002;
	localparam logic [31:0] ERR_HUM_SENSOR      = 32'h0000_0004;
	localparam logic [31:0] ERR_CAP_REF         = 32'h0000_0008;
	localparam logic [31:0] ERR_AMBIENT_TEMP    = 32'h0000_0010;
	localparam logic [31:0] ERR_FW_CHECKSUM     = 32'h0000_0020;
	localparam logic [31:0] ERR_DEV_SETTINGS    = 32'h0000_0040;
	localparam logic [31:0] ERR_ADD_CONFIG      = 32'h0000_0080;
	localparam logic [31:0] ERR_SENSOR_COEF     = 32'h0000_0100;
	localparam logic [31:0] ERR_MAIN_CONFIG     = 32'h0000_0200;
	localparam logic [31:0] ERR_SUPPLY_VOLTAGE  = 32'h0000_0800;
	localparam logic [31:0] ERR_NVM_ACCESS      = 32'h0000_2000;
	localparam logic [31:0] ERR_CAL_CHECKSUM    = 32'h0000_4000;
	localparam logic [31:0] ERR_DEFINED_MASK    = ERR_TEMP_MEAS | ERR_HUM_MEAS | ERR_HUM_SENSOR
		| ERR_CAP_REF | ERR_AMBIENT_TEMP | ERR_FW_CHECKSUM | ERR_DEV_SETTINGS | ERR_ADD_CONFIG
		| ERR_SENSOR_COEF | ERR_MAIN_CONFIG | ERR_SUPPLY_VOLTAGE | ERR_NVM_ACCESS
		| ERR_CAL_CHECKSUM;

	// Valid ranges and codes
	localparam logic [15:0] SLAVE_ID_MIN        = 16'h0001;
	localparam logic [15:0] SLAVE_ID_MAX        = 16'h00F7;
	localparam logic [15:0] BAUD_CODE_MIN       = 16'h0005;
	localparam logic [15:0] BAUD_CODE_MAX       = 16'h0008;
	localparam logic [15:0] FRAMING_CODE_MAX    = 16'h0005;
	localparam logic [15:0] REPLY_DELAY_MAX     = 16'h03FC;
	localparam logic [15:0] PROTOCOL_RTU        = 16'h0006;
	localparam logic [15:0] RESTART_COMMAND     = 16'h0001;

	// Values after reset
	localparam logic [31:0] SMOOTH_RESET        = 32'h3F80_0000;
	localparam logic [15:0] SLAVE_ID_RESET      = 16'h00F0;
	localparam logic [15:0] BAUD_RESET          = 16'h0006;
	localparam logic [15:0] FRAMING_RESET       = 16'h0001;
	localparam logic [15:0] REPLY_DELAY_RESET   = 16'h0000;
	localparam logic [15:0] PROTOCOL_RESET      = 16'h0006;

	// Fixed test values
	localparam logic [15:0] INT_TEST_VALUE      = 16'hCFC7;
	localparam logic [31:0] FLOAT_TEST_VALUE    = 32'hC2F6_E666;
	localparam logic [63:0] TEXT_TEST_VALUE     = 64'h2D31_3233_2E34_3500;

	// Exception answers
	localparam logic [7:0]  EXC_NONE            = 8'h00;
	localparam logic [7:0]  EXC_ILLEGAL_ADDR    = 8'h02;
	localparam logic [7:0]  EXC_ILLEGAL_VALUE   = 8'h03;

	localparam logic [31:0] HASH_SEED           = 32'h5A5A_C3C3;

	typedef struct packed {
		logic [31:0] smoothing_factor;
		logic [15:0] slave_id;
		logic [15:0] baud_select;
		logic [15:0] char_framing;
		logic [15:0] reply_delay_ms;
		logic [15:0] protocol_select;
	} probe_cfg_t;

	typedef struct packed {
		logic [15:0] baud_select;
		logic [15:0] char_framing;
	} link_cfg_t;

	// Pure function of its inputs, so undoing every change restores the value
	function automatic logic [31:0] settings_hash(input probe_cfg_t cfg, input logic [31:0] adj);
		logic [31:0] h;
		logic [31:0] w [0:6];
		h = HASH_SEED;
		w[0] = cfg.smoothing_factor;
		w[1] = {16'h0000, cfg.slave_id};
		w[2] = {16'h0000, cfg.baud_select};
		w[3] = {16'h0000, cfg.char_framing};
		w[4] = {16'h0000, cfg.reply_delay_ms};
		w[5] = {16'h0000, cfg.protocol_select};
		w[6] = adj;
		for (int i = 0; i < 7; i++)
		begin
			h = {h[26:0], h[31:27]} ^ w[i];
			h = h + {w[i][15:0], w[i][31:16]};
		end
		return h;
	endfunction

endpackage

// ### core/probe_modbus_config_status_regs.sv
// Holding-register bank: configuration, status and test registers of the probe.
// Assumes a protocol engine on the same clock presents one decoded 16-bit register access
// per request, and that error conditions and the adjustment signature are same-clock logic.
module probe_modbus_config_status_regs
	import probe_regs_pkg::*;
(
	input  wire logic        ref_clk_in,
	input  wire logic        reset_n_in,
	input  wire logic        req_in,
	input  wire logic        write_in,
	input  wire logic [15:0] addr_in,
	input  wire logic [15:0] wdata_in,
	input  wire logic [31:0] error_conditions_in,
	input  wire logic [31:0] adjust_signature_in,
	output logic             ack_out,
	output logic [15:0]      rdata_out,
	output logic [7:0]       exception_out,
	output logic             restart_out,
	output logic [31:0]      smoothing_factor_out,
	output logic [15:0]      slave_id_out,
	output logic [15:0]      reply_delay_ms_out,
	output logic [15:0]      protocol_select_out,
	output link_cfg_t        link_cfg_out
);

	probe_cfg_t  cfg_q,      cfg_d;
	link_cfg_t   link_q,     link_d;
	logic [15:0] smooth_lo_q, smooth_lo_d;
	logic [31:0] err_sum_q,  err_sum_d;
	logic [31:0] hash_q,     hash_d;
	logic        ack_q,      ack_d;
	logic [15:0] rdata_q,    rdata_d;
	logic [7:0]  exc_q,      exc_d;
	logic        restart_q,  restart_d;
	logic [15:0] text_word [0:3];

	function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		return (v >= lo) && (v <= hi);
	endfunction

	// Text test words, first character in the high byte of the first word
	for (genvar g = 0; g < 4; g++)
	begin : g_text_word
		assign text_word[g] = TEXT_TEST_VALUE[63 - 16 * g -: 16];
	end

	// Status words follow their sources one cycle late
	always_comb
	begin
		err_sum_d = error_conditions_in & ERR_DEFINED_MASK;
		hash_d    = settings_hash(cfg_q, adjust_signature_in);
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (!reset_n_in)
		begin
			err_sum_q <= 32'h0000_0000;
			hash_q    <= HASH_SEED;
		end
		else
		begin
			err_sum_q <= err_sum_d;
			hash_q    <= hash_d;
		end
	end

	always_comb
	begin
		cfg_d       = cfg_q;
		link_d      = link_q;
		smooth_lo_d = smooth_lo_q;
		ack_d       = req_in;
		rdata_d     = 16'h0000;
		exc_d       = EXC_NONE;
		restart_d   = 1'b0;
		if (req_in && write_in)
		begin
			unique case (addr_in)
				ADDR_SMOOTH_LO:
					smooth_lo_d = wdata_in;
				ADDR_SMOOTH_HI:
					cfg_d.smoothing_factor = {wdata_in, smooth_lo_q};
				ADDR_SLAVE_ID:
					if (in_range(wdata_in, SLAVE_ID_MIN, SLAVE_ID_MAX))
						cfg_d.slave_id = wdata_in;
					else
						exc_d = EXC_ILLEGAL_VALUE;
				ADDR_BAUD_SELECT:
					if (in_range(wdata_in, BAUD_CODE_MIN, BAUD_CODE_MAX))
						cfg_d.baud_select = wdata_in;
					else
						exc_d = EXC_ILLEGAL_VALUE;
				ADDR_CHAR_FRAMING:
					if (wdata_in <= FRAMING_CODE_MAX)
						cfg_d.char_framing = wdata_in;
					else
						exc_d = EXC_ILLEGAL_VALUE;
				ADDR_REPLY_DELAY:
					if (wdata_in <= REPLY_DELAY_MAX)
						cfg_d.reply_delay_ms = wdata_in;
					else
						exc_d = EXC_ILLEGAL_VALUE;
				ADDR_PROTOCOL:
					if (wdata_in == PROTOCOL_RTU)
						cfg_d.protocol_select = wdata_in;
					else
						exc_d = EXC_ILLEGAL_VALUE;
				ADDR_RESTART:
					if (wdata_in == RESTART_COMMAND)
					begin
						restart_d = 1'b1;
						link_d.baud_select  = cfg_q.baud_select;
						link_d.char_framing = cfg_q.char_framing;
					end
					else
						exc_d = EXC_ILLEGAL_VALUE;
				default:
					exc_d = EXC_ILLEGAL_ADDR;
			endcase
		end
		else if (req_in)
		begin
			unique case (addr_in)
				ADDR_ERROR_FLAG:
					rdata_d = (err_sum_q != 32'h0000_0000) ? ERROR_FLAG_ACTIVE
						: ERROR_FLAG_CLEAR;
				ADDR_ERROR_SUM_LO:
					rdata_d = err_sum_q[15:0];
				ADDR_ERROR_SUM_HI:
					rdata_d = err_sum_q[31:16];
				ADDR_HASH_LO:
					rdata_d = hash_q[15:0];
				ADDR_HASH_HI:
					rdata_d = hash_q[31:16];
				ADDR_SMOOTH_LO:
					rdata_d = cfg_q.smoothing_factor[15:0];
				ADDR_SMOOTH_HI:
					rdata_d = cfg_q.smoothing_factor[31:16];
				ADDR_SLAVE_ID:
					rdata_d = cfg_q.slave_id;
				ADDR_BAUD_SELECT:
					rdata_d = cfg_q.baud_select;
				ADDR_CHAR_FRAMING:
					rdata_d = cfg_q.char_framing;
				ADDR_REPLY_DELAY:
					rdata_d = cfg_q.reply_delay_ms;
				ADDR_PROTOCOL:
					rdata_d = cfg_q.protocol_select;
				ADDR_INT_TEST:
					rdata_d = INT_TEST_VALUE;
				ADDR_FLOAT_TEST_LO:
					rdata_d = FLOAT_TEST_VALUE[15:0];
				ADDR_FLOAT_TEST_HI:
					rdata_d = FLOAT_TEST_VALUE[31:16];
				ADDR_TEXT_TEST_0:
					rdata_d = text_word[0];
				ADDR_TEXT_TEST_1:
					rdata_d = text_word[1];
				ADDR_TEXT_TEST_2:
					rdata_d = text_word[2];
				ADDR_TEXT_TEST_3:
					rdata_d = text_word[3];
				// Restart register is write-only; unmapped reads are refused
				default:            exc_d = EXC_ILLEGAL_ADDR;
			endcase
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (!reset_n_in)
		begin
			cfg_q.smoothing_factor <= SMOOTH_RESET;
			cfg_q.slave_id         <= SLAVE_ID_RESET;
			cfg_q.baud_select      <= BAUD_RESET;
			cfg_q.char_framing     <= FRAMING_RESET;
			cfg_q.reply_delay_ms   <= REPLY_DELAY_RESET;
			cfg_q.protocol_select  <= PROTOCOL_RESET;
			link_q.baud_select     <= BAUD_RESET;
			link_q.char_framing    <= FRAMING_RESET;
			smooth_lo_q            <= 16'h0000;
			ack_q                  <= 1'b0;
			rdata_q                <= 16'h0000;
			exc_q                  <= EXC_NONE;
			restart_q              <= 1'b0;
		end
		else
		begin
			cfg_q       <= cfg_d;
			link_q      <= link_d;
			smooth_lo_q <= smooth_lo_d;
			ack_q       <= ack_d;
			rdata_q     <= rdata_d;
			exc_q       <= exc_d;
			restart_q   <= restart_d;
		end
	end

	assign ack_out              = ack_q;
	assign rdata_out            = rdata_q;
	assign exception_out        = exc_q;
	assign restart_out          = restart_q;
	assign smoothing_factor_out = cfg_q.smoothing_factor;
	assign slave_id_out         = cfg_q.slave_id;
	assign reply_delay_ms_out   = cfg_q.reply_delay_ms;
	assign protocol_select_out  = cfg_q.protocol_select;
	assign link_cfg_out         = link_q;

endmodule // probe_modbus_config_status_regs

// ### sim/probe_regs_checker_assertions.sv
// Port checks for the holding-register bank.
// Assumes the single clock domain and synchronous active-low reset of the bank.
module probe_regs_checker
	import probe_regs_pkg::*;
(
	input  wire logic        ref_clk_in,
	input  wire logic        reset_n_in,
	input  wire logic        req_in,
	input  wire logic        write_in,
	input  wire logic [15:0] addr_in,
	input  wire logic [15:0] wdata_in,
	input  wire logic [31:0] error_conditions_in,
	input  wire logic        ack_out,
	input  wire logic [15:0] rdata_out,
	input  wire logic [7:0]  exception_out,
	input  wire logic        restart_out,
	input  wire logic [15:0] slave_id_out,
	input  wire link_cfg_t   link_cfg_out
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!reset_n_in);
	chk_ack_next: assert property (req_in |=> ack_out) else $error("No answer after request");
	chk_ack_only: assert property (!req_in |=> !ack_out) else $error("Answer without request");
	chk_flag_value:
		assert property (req_in && !write_in && addr_in == ADDR_ERROR_FLAG |=> rdata_out ==
			((|($past(error_conditions_in, 2) & ERR_DEFINED_MASK)) ? ERROR_FLAG_ACTIVE
			: ERROR_FLAG_CLEAR)) else $error("Error flag wrong");
	chk_sum_low:
		assert property (req_in && !write_in && addr_in == ADDR_ERROR_SUM_LO |=> {16'h0000,
			rdata_out} == ($past(error_conditions_in, 2) & ERR_DEFINED_MASK & 32'h0000_FFFF))
			else $error("Error sum wrong");
	chk_sum_high:
		assert property (req_in && !write_in && addr_in == ADDR_ERROR_SUM_HI
			|=> rdata_out == 16'h0000) else $error("Error sum high word not zero");
	chk_int_test:
		assert property (req_in && !write_in && addr_in == ADDR_INT_TEST |=> rdata_out ==
			INT_TEST_VALUE && exception_out == EXC_NONE) else $error("Integer test wrong");
	chk_link_hold: assert property ($changed(link_cfg_out) |-> restart_out)
		else $error("Link settings changed without restart");
	chk_restart_cmd:
		assert property (req_in && write_in && addr_in == ADDR_RESTART && wdata_in ==
			RESTART_COMMAND |=> restart_out && ack_out) else $error("Restart not pulsed");
	chk_id_range:
		assert property (req_in && write_in && addr_in == ADDR_SLAVE_ID && (wdata_in <
			SLAVE_ID_MIN || wdata_in > SLAVE_ID_MAX) |=> exception_out == EXC_ILLEGAL_VALUE
			&& $stable(slave_id_out)) else $error("Bad address accepted");
	cover property (restart_out);
	cover property (ack_out && exception_out == EXC_ILLEGAL_VALUE);
	cover property (req_in ##1 req_in);
endmodule // probe_regs_checker

bind probe_modbus_config_status_regs probe_regs_checker i_chk (.ref_clk_in(ref_clk_in),
	.reset_n_in(reset_n_in), .req_in(req_in), .write_in(write_in), .addr_in(addr_in),
	.wdata_in(wdata_in), .error_conditions_in(error_conditions_in), .ack_out(ack_out),
	.rdata_out(rdata_out), .exception_out(exception_out), .restart_out(restart_out),
	.slave_id_out(slave_id_out), .link_cfg_out(link_cfg_out));

// ### sim/modbus_master_model.sv
// Register-access master in place of the serial protocol engine.
// Assumes every request is answered on the edge that takes it, and reads the answer at the next falling edge.
module modbus_master_model
	import probe_regs_pkg::*;
(
	input  wire logic        ref_clk_in,
	input  wire logic        ack_in,
	input  wire logic [15:0] rdata_in,
	input  wire logic [7:0]  exc_in,
	output logic             req_out = 1'b0,
	output logic             write_out = 1'b0,
	output logic [15:0]      addr_out = 16'h0000,
	output logic [15:0]      wdata_out = 16'h0000
);
	timeunit 1ns;
	timeprecision 100ps;
	task automatic drive(input logic w, input logic [15:0] a, input logic [15:0] d);
		req_out = 1'b1;
		write_out = w;
		addr_out = a;
		wdata_out = d;
	endtask
	// Released lines show the inverse, never the last value
	task automatic idle(input logic [15:0] a, input logic [15:0] d);
		req_out = 1'b0;
		write_out = ~write_out;
		addr_out = ~a;
		wdata_out = ~d;
	endtask
	task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
		output logic [15:0] r, output logic [7:0] e, output logic k);
		@(negedge ref_clk_in);
		drive(w, a, d);
		@(negedge ref_clk_in);
		k = ack_in;
		r = rdata_in;
		e = exc_in;
		idle(a, d);
	endtask
	task automatic xfer32(input logic w, input logic [15:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic ok);
		@(negedge ref_clk_in);
		drive(w, a, d[15:0]);
		@(negedge ref_clk_in);
		ok = ack_in && exc_in == EXC_NONE;
		r[15:0] = rdata_in;
		drive(w, a + 16'h0001, d[31:16]);
		@(negedge ref_clk_in);
		ok = ok && ack_in && exc_in == EXC_NONE;
		r[31:16] = rdata_in;
		idle(a, d[31:16]);
	endtask
endmodule // modbus_master_model

// ### sim/test_probe_modbus_config_status_regs.sv
// Self-checking bench for the holding-register bank.
// Assumes the bank answers one cycle after each request, with no stalls.
module test_probe_modbus_config_status_regs
	import probe_regs_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic        ref_clk_in = 1'b0;
	logic        reset_n_in = 1'b0;
	logic        req, wr_en, ack, restart;
	logic [15:0] addr, wdata, rdata, sid, dly, proto;
	logic [7:0]  exc;
	logic [31:0] err_in = 32'h0000_0000;
	logic [31:0] adj_in = 32'h0000_0000;
	logic [31:0] smooth;
	link_cfg_t   link;
	int          n_errors = 0;
	int          comparisons = 0;
	always #2.5 ref_clk_in = ~ref_clk_in;
	probe_modbus_config_status_regs i_dut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
		.req_in(req), .write_in(wr_en), .addr_in(addr), .wdata_in(wdata),
		.error_conditions_in(err_in), .adjust_signature_in(adj_in), .ack_out(ack),
		.rdata_out(rdata), .exception_out(exc), .restart_out(restart),
		.smoothing_factor_out(smooth), .slave_id_out(sid), .reply_delay_ms_out(dly),
		.protocol_select_out(proto), .link_cfg_out(link));
	modbus_master_model i_master (.ref_clk_in(ref_clk_in), .ack_in(ack), .rdata_in(rdata),
		.exc_in(exc), .req_out(req), .write_out(wr_en), .addr_out(addr), .wdata_out(wdata));
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
		input logic [15:0] exp, input logic [7:0] ee = EXC_NONE);
		logic [15:0] r;
		logic [7:0]  e;
		logic        k;
		i_master.xfer(w, a, d, r, e, k);
		cmp({k, 7'h00, e, r}, {1'b1, 7'h00, ee, exp});
	endtask
	task automatic get32(input logic [15:0] a, output logic [31:0] v);
		logic ok;
		i_master.xfer32(1'b0, a, 32'h0000_0000, v, ok);
		cmp(ok, 1'b1);
	endtask
	task automatic t_resets_and_tests;
		logic [31:0] v;
		logic        ok;
		acc(0, ADDR_SLAVE_ID, 0, 16'h00F0);
		acc(0, ADDR_BAUD_SELECT, 0, 16'h0006);
		acc(0, ADDR_CHAR_FRAMING, 0, 16'h0001);
		acc(0, ADDR_PROTOCOL, 0, 16'h0006);
		cmp(link, 32'h0006_0001);
		acc(0, ADDR_INT_TEST, 0, 16'hCFC7);
		acc(1, ADDR_INT_TEST, 1, 16'h0000, EXC_ILLEGAL_ADDR);
		get32(ADDR_FLOAT_TEST_LO, v);
		cmp(v, 32'hC2F6_E666);
		get32(ADDR_TEXT_TEST_0, v);
		cmp(v, 32'h3233_2D31);
		get32(ADDR_TEXT_TEST_2, v);
		cmp(v, 32'h3500_2E34);
		i_master.xfer32(1'b1, ADDR_SMOOTH_LO, 32'h3A83_126F, v, ok);
		cmp(ok, 1'b1);
		cmp(smooth, 32'h3A83_126F);
		get32(ADDR_SMOOTH_LO, v);
		cmp(v, 32'h3A83_126F);
	endtask
	task automatic t_errors;
		logic [31:0] v;
		logic [31:0] wt [13] = '{1, 2, 4, 8, 16, 32, 64, 128, 256, 512, 2048, 8192, 16384};
		foreach (wt[i])
		begin
			err_in = wt[i];
			acc(0, ADDR_ERROR_FLAG, 0, 16'h0000);
			get32(ADDR_ERROR_SUM_LO, v);
			cmp(v, wt[i]);
		end
		err_in = 32'hFFFF_FFFF;
		get32(ADDR_ERROR_SUM_LO, v);
		cmp(v, 32'h0000_6BFF);
		err_in = 32'h0000_1400;
		acc(0, ADDR_ERROR_FLAG, 0, 16'h0001);
		err_in = 32'h0000_0000;
		acc(0, ADDR_ERROR_FLAG, 0, 16'h0001);
	endtask
	task automatic t_hash;
		logic [31:0] h0, h1;
		get32(ADDR_HASH_LO, h0);
		acc(1, ADDR_REPLY_DELAY, 16'h03FC, 0);
		get32(ADDR_HASH_LO, h1);
		cmp(h1 != h0, 1);
		acc(1, ADDR_REPLY_DELAY, 0, 0);
		get32(ADDR_HASH_LO, h1);
		cmp(h1, h0);
		adj_in = 32'h0000_0001;
		get32(ADDR_HASH_LO, h1);
		cmp(h1 != h0, 1);
		adj_in = 32'h0000_0000;
		get32(ADDR_HASH_LO, h1);
		cmp(h1, h0);
	endtask
	task automatic t_link_and_refusals;
		for (int c = 5; c <= 8; c++)
			acc(1, ADDR_BAUD_SELECT, 16'(c), 0);
		for (int c = 0; c <= 5; c++)
			acc(1, ADDR_CHAR_FRAMING, 16'(c), 0);
		acc(1, ADDR_BAUD_SELECT, 16'h0004, 0, EXC_ILLEGAL_VALUE);
		acc(1, ADDR_CHAR_FRAMING, 16'h0006, 0, EXC_ILLEGAL_VALUE);
		cmp(link, 32'h0006_0001);
		acc(1, ADDR_RESTART, 16'h0002, 0, EXC_ILLEGAL_VALUE);
		cmp(restart, 1'b0);
		acc(1, ADDR_RESTART, RESTART_COMMAND, 0);
		cmp(restart, 1'b1);
		cmp(link, 32'h0008_0005);
		acc(0, ADDR_RESTART, 0, 0, EXC_ILLEGAL_ADDR);
		acc(1, ADDR_SLAVE_ID, 16'h0000, 0, EXC_ILLEGAL_VALUE);
		acc(1, ADDR_SLAVE_ID, 16'h00F8, 0, EXC_ILLEGAL_VALUE);
		acc(1, ADDR_SLAVE_ID, 16'h00F7, 0);
		cmp(sid, 16'h00F7);
		acc(1, ADDR_REPLY_DELAY, 16'h03FD, 0, EXC_ILLEGAL_VALUE);
		acc(1, ADDR_PROTOCOL, 16'h0007, 0, EXC_ILLEGAL_VALUE);
		cmp({dly, proto}, 32'h0000_0006);
		acc(1, ADDR_ERROR_FLAG, 1, 0, EXC_ILLEGAL_ADDR);
		acc(0, 16'h01FF, 0, 0, EXC_ILLEGAL_ADDR);
	endtask
	// Mid-run reset must bring stored and active settings back to their reset values
	task automatic t_reset_again;
		@(negedge ref_clk_in);
		reset_n_in = 1'b0;
		repeat (2) @(negedge ref_clk_in);
		reset_n_in = 1'b1;
		cmp(link, 32'h0006_0001);
		cmp(sid, 16'h00F0);
		acc(0, ADDR_SLAVE_ID, 0, 16'h00F0);
		acc(0, ADDR_BAUD_SELECT, 0, 16'h0006);
	endtask
	task automatic complete_run;
		$display("Comparisons %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		#50us;
		n_errors++;
		complete_run();
	end
	initial
	begin
		repeat (10) @(negedge ref_clk_in);
		reset_n_in = 1'b1;
		repeat (2) @(negedge ref_clk_in);
		t_resets_and_tests();
		t_errors();
		t_hash();
		t_link_and_refusals();
		t_reset_again();
		complete_run();
	end
endmodule // test_probe_modbus_config_status_regs
